// ### logic/msac_pkg.sv
// Functional notes
// - Inputs zero to three form group 0 and inputs four to seven group 1.
// - Four result registers A to D each read back a stored 16-bit result.
// - Scan selector 1 selects scan mode; group select 0 picks group 0.
// - Group 0 scan with channel bits high=1 low=0 scans inputs 0, 1 and 2.
// - Software sets mode, group, channels, then the start bit starts it.
// - A DMA access triggered by the end interrupt clears the end flag.
package msac_pkg;
    localparam logic [3:0] ADDR_CTRL = 4'h0;
    localparam logic [3:0] ADDR_RES_A = 4'h1;
    localparam logic [3:0] ADDR_RES_B = 4'h2;
    localparam logic [3:0] ADDR_RES_C = 4'h3;
    localparam logic [3:0] ADDR_RES_D = 4'h4;
    localparam logic [3:0] ADDR_IRQ_STAT = 4'h5;
    localparam logic [3:0] ADDR_IRQ_MASK = 4'h6;
    localparam int CTL_CH_LO = 0;
    localparam int CTL_CH_HI = 1;
    localparam int CTL_GROUP = 2;
    localparam int CTL_SCAN = 4;
    localparam int CTL_START = 5;
    localparam int CTL_END = 7;
    localparam logic [15:0] CTRL_RESET = 16'h0000;
    localparam int CONV_CYCLES = 16;
    typedef enum logic [1:0] {
        MS_IDLE = 2'b00,
        MS_CONV = 2'b01,
        MS_STORE = 2'b10
    } msac_state_t;
endpackage

// ### logic/msac_conv_if.sv
`timescale 1ns/1ns
interface msac_conv_if;
    logic start;
    logic [2:0] chan;
    logic done;
    logic [15:0] result;
    modport ctrl (output start, output chan, input done, input result);
    modport conv (input start, input chan, output done, output result);
endinterface

// ### logic/msac_converter.sv
`timescale 1ns/1ns
module msac_converter #(
    parameter int CYCLES = msac_pkg::CONV_CYCLES
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic [7:0][15:0] samples_in,
    msac_conv_if.conv cv
);
    logic [7:0] cnt_r, cnt_nxt;
    logic busy_r, busy_nxt;
    logic done_r, done_nxt;
    logic [15:0] res_r, res_nxt;
    logic [2:0] ch_r, ch_nxt;
    assign cv.done = done_r;
    assign cv.result = res_r;
    always_comb begin
        cnt_nxt = cnt_r;
        busy_nxt = busy_r;
        done_nxt = 1'b0;
        res_nxt = res_r;
        ch_nxt = ch_r;
        if (!busy_r && cv.start) begin
            busy_nxt = 1'b1;
            cnt_nxt = 8'(CYCLES - 1);
            ch_nxt = cv.chan;
        end else if (busy_r) begin
            if (cnt_r == 8'h00) begin
                busy_nxt = 1'b0;
                done_nxt = 1'b1;
                res_nxt = samples_in[ch_r];
            end else begin
                cnt_nxt = cnt_r - 8'h01;
            end
        end
    end
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            cnt_r <= 8'h00;
            busy_r <= 1'b0;
            done_r <= 1'b0;
            res_r <= 16'h0000;
            ch_r <= 3'h0;
        end else begin
            cnt_r <= cnt_nxt;
            busy_r <= busy_nxt;
            done_r <= done_nxt;
            res_r <= res_nxt;
            ch_r <= ch_nxt;
        end
    end
endmodule

// ### logic/msac_top.sv
`timescale 1ns/1ns
module msac_top #(
    parameter int CYCLES = msac_pkg::CONV_CYCLES
) (
    input wire logic SYS_CLK_IN,
    input wire logic RST_N_IN,
    input wire logic [15:0] ANALOG_INPUT_ZERO_IN,
    input wire logic [15:0] ANALOG_INPUT_ONE_IN,
    input wire logic [15:0] ANALOG_INPUT_TWO_IN,
    input wire logic [15:0] ANALOG_INPUT_THREE_IN,
    input wire logic [15:0] ANALOG_INPUT_FOUR_IN,
    input wire logic [15:0] ANALOG_INPUT_FIVE_IN,
    input wire logic [15:0] ANALOG_INPUT_SIX_IN,
    input wire logic [15:0] ANALOG_INPUT_SEVEN_IN,
    input wire logic [3:0] ADDR_IN,
    input wire logic [15:0] WDATA_IN,
    input wire logic WR_IN,
    input wire logic RD_IN,
    input wire logic DMA_ACCESS_IN,
    output logic [15:0] RDATA_OUT,
    output logic CONVERSION_END_IRQ_OUT,
    output logic IRQ_OUT
);
    logic [7:0][15:0] s1_r, s2_r;
    logic [15:0] ctrl_r, ctrl_nxt;
    logic [3:0][15:0] res_r, res_nxt;
    logic stat_r, stat_nxt, mask_r, mask_nxt;
    logic [15:0] rdata_r, rdata_nxt;
    logic irq_r, irq_nxt, endirq_r, endirq_nxt;
    msac_pkg::msac_state_t st_r, st_nxt;
    logic [2:0] ch_r, ch_nxt;
    logic [1:0] slot_r, slot_nxt;
    logic start_r, start_nxt;
    logic [2:0] first_ch, last_ch;
    logic pass_end;
    msac_conv_if cv ();
    assign cv.start = start_r;
    assign cv.chan = ch_r;
    // Sampled inputs pass two flops as they come from the analog side
    always_ff @(posedge SYS_CLK_IN) begin
        if (!RST_N_IN) begin
            s1_r <= '0;
            s2_r <= '0;
        end else begin
            s1_r <= {ANALOG_INPUT_SEVEN_IN, ANALOG_INPUT_SIX_IN,
                ANALOG_INPUT_FIVE_IN, ANALOG_INPUT_FOUR_IN,
                ANALOG_INPUT_THREE_IN, ANALOG_INPUT_TWO_IN,
                ANALOG_INPUT_ONE_IN, ANALOG_INPUT_ZERO_IN};
            s2_r <= s1_r;
        end
    end
    msac_converter #(.CYCLES(CYCLES)) u_conv (
        .clk_in(SYS_CLK_IN),
        .rst_n_in(RST_N_IN),
        .samples_in(s2_r),
        .cv(cv.conv)
    );
    always_comb begin
        // group bit forms top channel bit
        first_ch = {ctrl_r[msac_pkg::CTL_GROUP], 2'b00};
        // last scanned channel from select bits
        last_ch = {ctrl_r[msac_pkg::CTL_GROUP],
            ctrl_r[msac_pkg::CTL_CH_HI], ctrl_r[msac_pkg::CTL_CH_LO]};
        // scan mode starts at group base
        if (!ctrl_r[msac_pkg::CTL_SCAN]) begin
            first_ch = last_ch;
        end
    end
    always_comb begin
        st_nxt = st_r;
        ch_nxt = ch_r;
        slot_nxt = slot_r;
        start_nxt = 1'b0;
        res_nxt = res_r;
        pass_end = 1'b0;
        case (st_r)
            msac_pkg::MS_IDLE: begin
                if (ctrl_r[msac_pkg::CTL_START]) begin
                    ch_nxt = first_ch;
                    slot_nxt = first_ch[1:0];
                    start_nxt = 1'b1;
                    st_nxt = msac_pkg::MS_CONV;
                end
            end
            msac_pkg::MS_CONV: begin
                if (cv.done) begin
                    res_nxt[slot_r] = cv.result;
                    st_nxt = msac_pkg::MS_STORE;
                end
            end
            msac_pkg::MS_STORE: begin
                // Start cleared: stop after the channel in flight
                if (!ctrl_r[msac_pkg::CTL_START]) begin
                    st_nxt = msac_pkg::MS_IDLE;
                end else if (ch_r == last_ch) begin
                    pass_end = 1'b1;
                    // Scan repeats while start stays set
                    if (ctrl_r[msac_pkg::CTL_SCAN]) begin
                        ch_nxt = first_ch;
                        slot_nxt = first_ch[1:0];
                        start_nxt = 1'b1;
                        st_nxt = msac_pkg::MS_CONV;
                    end else begin
                        st_nxt = msac_pkg::MS_IDLE;
                    end
                end else begin
                    ch_nxt = ch_r + 3'h1;
                    slot_nxt = slot_r + 2'h1;
                    start_nxt = 1'b1;
                    st_nxt = msac_pkg::MS_CONV;
                end
            end
            default: begin
                st_nxt = msac_pkg::MS_IDLE;
            end
        endcase
    end
    always_comb begin
        ctrl_nxt = ctrl_r;
        stat_nxt = stat_r;
        mask_nxt = mask_r;
        rdata_nxt = 16'h0000;
        if (WR_IN && ADDR_IN == msac_pkg::ADDR_CTRL) begin
            ctrl_nxt[6:0] = WDATA_IN[6:0];
            ctrl_nxt[15:8] = 8'h00;
            ctrl_nxt[3] = 1'b0;
            // A write can only clear the end flag, by writing zero
            if (!WDATA_IN[msac_pkg::CTL_END]) begin
                ctrl_nxt[msac_pkg::CTL_END] = 1'b0;
            end
        end
        if (WR_IN && ADDR_IN == msac_pkg::ADDR_IRQ_STAT && WDATA_IN[0]) begin
            stat_nxt = 1'b0;
        end
        if (WR_IN && ADDR_IN == msac_pkg::ADDR_IRQ_MASK) begin
            mask_nxt = WDATA_IN[0];
        end
        if (DMA_ACCESS_IN && (RD_IN || WR_IN) && endirq_r) begin
            ctrl_nxt[msac_pkg::CTL_END] = 1'b0;
        end
        if (pass_end) begin
            // pass end sets flag, set wins
            ctrl_nxt[msac_pkg::CTL_END] = 1'b1;
            stat_nxt = 1'b1;
            if (!ctrl_r[msac_pkg::CTL_SCAN]) begin
                ctrl_nxt[msac_pkg::CTL_START] = 1'b0;
            end
        end
        if (RD_IN) begin
            case (ADDR_IN)
                msac_pkg::ADDR_CTRL: rdata_nxt = ctrl_r;
                msac_pkg::ADDR_RES_A: rdata_nxt = res_r[0];
                msac_pkg::ADDR_RES_B: rdata_nxt = res_r[1];
                msac_pkg::ADDR_RES_C: rdata_nxt = res_r[2];
                msac_pkg::ADDR_RES_D: rdata_nxt = res_r[3];
                msac_pkg::ADDR_IRQ_STAT: rdata_nxt = {15'h0000, stat_r};
                msac_pkg::ADDR_IRQ_MASK: rdata_nxt = {15'h0000, mask_r};
                default: rdata_nxt = 16'h0000;
            endcase
        end
        endirq_nxt = ctrl_nxt[msac_pkg::CTL_END];
        irq_nxt = stat_nxt & mask_nxt;
    end
    always_ff @(posedge SYS_CLK_IN) begin
        if (!RST_N_IN) begin
            ctrl_r <= msac_pkg::CTRL_RESET;
            stat_r <= 1'b0;
            mask_r <= 1'b0;
            rdata_r <= 16'h0000;
            irq_r <= 1'b0;
            endirq_r <= 1'b0;
            st_r <= msac_pkg::MS_IDLE;
            ch_r <= 3'h0;
            slot_r <= 2'h0;
            start_r <= 1'b0;
            res_r <= '0;
        end else begin
            ctrl_r <= ctrl_nxt;
            stat_r <= stat_nxt;
            mask_r <= mask_nxt;
            rdata_r <= rdata_nxt;
            irq_r <= irq_nxt;
            endirq_r <= endirq_nxt;
            st_r <= st_nxt;
            ch_r <= ch_nxt;
            slot_r <= slot_nxt;
            start_r <= start_nxt;
            res_r <= res_nxt;
        end
    end
    assign RDATA_OUT = rdata_r;
    assign IRQ_OUT = irq_r;
    assign CONVERSION_END_IRQ_OUT = endirq_r;
endmodule

// ### testbench/msac_far_model.sv
`timescale 1ns/1ns
module msac_far_model #(
    parameter logic [15:0] BASE = 16'hA000,
    parameter logic [15:0] STEP = 16'h0111
) (
    output logic [7:0][15:0] ana_out
);
    // two input groups
    // Static levels: any slot mix-up shows
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            ana_out[i] = BASE + 16'(i) * STEP;
        end
    end
endmodule

// ### testbench/msac_top_sva.sv
`timescale 1ns/1ns
module msac_top_sva #(
    parameter int CYCLES = 16
) (
    input wire logic SYS_CLK_IN,
    input wire logic RST_N_IN,
    input wire logic [3:0] ADDR_IN,
    input wire logic [15:0] WDATA_IN,
    input wire logic WR_IN,
    input wire logic RD_IN,
    input wire logic DMA_ACCESS_IN,
    input wire logic [15:0] RDATA_OUT,
    input wire logic CONVERSION_END_IRQ_OUT,
    input wire logic IRQ_OUT
);
    localparam int END_MAX = CYCLES + 10;
    logic wr_ctl;
    assign wr_ctl = WR_IN && ADDR_IN == msac_pkg::ADDR_CTRL;
    default clocking @(posedge SYS_CLK_IN); endclocking
    default disable iff (!RST_N_IN);
    rdata_idle_a: assert property (
        !$past(RD_IN) |-> RDATA_OUT == 16'h0000) else $error("stray data");
    unmapped_read_a: assert property (
        RD_IN && ADDR_IN > msac_pkg::ADDR_IRQ_MASK |=> RDATA_OUT == 16'h0000)
        else $error("unmapped read not zero");
    ctrl_reserved_a: assert property (
        RD_IN && ADDR_IN == msac_pkg::ADDR_CTRL
        |=> !RDATA_OUT[3] && RDATA_OUT[15:8] == 8'h00)
        else $error("reserved ctrl bits set");
    single_end_a: assert property (
        wr_ctl && WDATA_IN[5] && !WDATA_IN[4]
        |-> ##[1:END_MAX] CONVERSION_END_IRQ_OUT) else $error("no end flag");
    dma_clear_a: assert property (
        (WR_IN || RD_IN) && DMA_ACCESS_IN && CONVERSION_END_IRQ_OUT
        |-> ##[1:2] !CONVERSION_END_IRQ_OUT) else $error("dma left flag");
    sw_clear_a: assert property (
        wr_ctl && !WDATA_IN[7] && !WDATA_IN[5]
        |-> ##[1:2] !CONVERSION_END_IRQ_OUT) else $error("flag not cleared");
    status_clear_a: assert property (
        WR_IN && ADDR_IN == msac_pkg::ADDR_IRQ_STAT && WDATA_IN[0]
        && !CONVERSION_END_IRQ_OUT |-> ##2 !IRQ_OUT) else $error("w1c fail");
    mask_off_a: assert property (
        WR_IN && ADDR_IN == msac_pkg::ADDR_IRQ_MASK && !WDATA_IN[0]
        |=> !IRQ_OUT) else $error("masked irq high");
endmodule
bind msac_top msac_top_sva #(.CYCLES(CYCLES)) sva_u (.SYS_CLK_IN, .RST_N_IN,
    .ADDR_IN, .WDATA_IN, .WR_IN, .RD_IN, .DMA_ACCESS_IN, .RDATA_OUT,
    .CONVERSION_END_IRQ_OUT, .IRQ_OUT);

// ### testbench/tb_msac_top.sv
`timescale 1ns/1ns
module tb_msac_top;
    localparam logic [15:0] BASE = 16'hA000;
    localparam logic [15:0] STEP = 16'h0111;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [15:0] wdata = 16'h0000;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic dma = 1'b0;
    logic [15:0] rdata;
    logic end_irq;
    logic irq;
    logic [7:0][15:0] ana;
    logic [15:0] got;
    int fails = 0;
    int comparisons = 0;
    int ticks = 0;
    msac_far_model #(.BASE(BASE), .STEP(STEP)) far_u (.ana_out(ana));
    msac_top #(.CYCLES(2)) dut_u (.SYS_CLK_IN(clk), .RST_N_IN(rst_n),
        .ANALOG_INPUT_ZERO_IN(ana[0]), .ANALOG_INPUT_ONE_IN(ana[1]),
        .ANALOG_INPUT_TWO_IN(ana[2]), .ANALOG_INPUT_THREE_IN(ana[3]),
        .ANALOG_INPUT_FOUR_IN(ana[4]), .ANALOG_INPUT_FIVE_IN(ana[5]),
        .ANALOG_INPUT_SIX_IN(ana[6]), .ANALOG_INPUT_SEVEN_IN(ana[7]),
        .ADDR_IN(addr), .WDATA_IN(wdata), .WR_IN(wr), .RD_IN(rd),
        .DMA_ACCESS_IN(dma), .RDATA_OUT(rdata),
        .CONVERSION_END_IRQ_OUT(end_irq), .IRQ_OUT(irq));
    initial begin
        forever #25 clk = ~clk;
    end
    task automatic final_report();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // Hang guard well above the fewer than two hundred cycles needed
    always @(posedge clk) begin
        ticks <= ticks + 1;
        if (ticks == 3000) begin
            fails++;
            final_report();
        end
    end
    task automatic chk(input string nm, input logic [15:0] e,
                       input logic [15:0] s);
        comparisons++;
        if (s !== e) begin
            fails++;
            $display("BAD %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic wr_reg(input logic [3:0] a, input logic [15:0] d,
                          input logic dm);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        dma <= dm;
        @(posedge clk);
        wr <= 1'b0;
        dma <= 1'b0;
    endtask
    task automatic rd_reg(input logic [3:0] a, input logic dm,
                          output logic [15:0] v);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        dma <= dm;
        @(posedge clk);
        rd <= 1'b0;
        dma <= 1'b0;
        #1 v = rdata;
    endtask
    task automatic wait_end();
        int n;
        n = 0;
        while (end_irq !== 1'b1 && n < 100) begin
            @(posedge clk);
            #1 n++;
        end
        chk("end flag", 16'h0001, {15'h0, end_irq});
    endtask
    initial begin
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        rd_reg(msac_pkg::ADDR_CTRL, 1'b0, got);
        chk("ctrl reset", msac_pkg::CTRL_RESET, got);
        wr_reg(msac_pkg::ADDR_IRQ_MASK, 16'h0001, 1'b0);
        // Selections first, start afterwards
        wr_reg(msac_pkg::ADDR_CTRL, 16'h0012, 1'b0);
        wr_reg(msac_pkg::ADDR_CTRL, 16'h0032, 1'b0);
        wait_end();
        chk("irq", 16'h0001, {15'h0, irq});
        wr_reg(msac_pkg::ADDR_CTRL, 16'h0012, 1'b0);
        for (int i = 0; i < 3; i++) begin
            rd_reg(msac_pkg::ADDR_RES_A + 4'(i), 1'b0, got);
            chk("scan result", BASE + 16'(i) * STEP, got);
        end
        repeat (40) @(posedge clk);
        chk("scan stop", 16'h0000, {15'h0, end_irq});
        wr_reg(msac_pkg::ADDR_CTRL, 16'h0000, 1'b0);
        wr_reg(msac_pkg::ADDR_IRQ_STAT, 16'h0001, 1'b0);
        @(posedge clk);
        #1 chk("irq cleared", 16'h0000, {15'h0, irq});
        // Single conversions, DMA reads the slot to clear the flag
        for (int k = 0; k < 3; k++) begin
            wr_reg(msac_pkg::ADDR_CTRL, 16'h0023 + 16'(2 * k), 1'b0);
            wait_end();
            rd_reg(k == 1 ? msac_pkg::ADDR_RES_B : msac_pkg::ADDR_RES_D,
                   1'b1, got);
            chk("single result", BASE + 16'(3 + 2 * k) * STEP, got);
            @(posedge clk);
            #1 chk("dma clear", 16'h0000, {15'h0, end_irq});
            chk("sticky irq", 16'h0001, {15'h0, irq});
        end
        wr_reg(msac_pkg::ADDR_IRQ_MASK, 16'h0000, 1'b0);
        @(posedge clk);
        #1 chk("masked irq", 16'h0000, {15'h0, irq});
        wr_reg(msac_pkg::ADDR_IRQ_MASK, 16'h0001, 1'b0);
        @(posedge clk);
        #1 chk("unmasked irq", 16'h0001, {15'h0, irq});
        wr_reg(4'hF, 16'hFFFF, 1'b0);
        rd_reg(4'hF, 1'b0, got);
        chk("unmapped", 16'h0000, got);
        rd_reg(msac_pkg::ADDR_CTRL, 1'b0, got);
        chk("ctrl after single", 16'h0007, got);
        final_report();
    end
endmodule
